// ### lptc_pkg.sv
// Constants, register map and carrier types for the translation cache.
// Assumes a single aclk domain and AXI4-Lite register access.
package lptc_pkg;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DIRBASE = 8'h04;
   localparam logic [7:0] REG_PRIV = 8'h08;
   localparam logic [7:0] REG_INVPAGE = 8'h0c;
   localparam logic [7:0] REG_INVALL = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_MISSES = 8'h18;
   localparam int CTRL_PAGING_ON = 0;
   localparam int CTRL_EXT_TABLE = 1;
   localparam int CTRL_SIZE_EXT = 2;
   localparam int CTRL_GLOBAL_EN = 3;
   localparam int ST_DENIED = 0;
   localparam int ST_BUSY = 1;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [19:0] DIRBASE_RESET = 20'h00000;
   localparam logic [1:0] PRIV_RESET = 2'h0;
   localparam int ENT_PRESENT = 0;
   localparam int ENT_WRITE_THRU = 3;
   localparam int ENT_CACHE_DIS = 4;
   localparam int ENT_SMALL_ATTR = 7;
   localparam int ENT_PAGE_SIZE = 7;
   localparam int ENT_GLOBAL = 8;
   localparam int ENT_LARGE_ATTR = 12;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int TLB_ENTRIES_DEF = 8;
   localparam int TLB_COUNT = 4;
   localparam int TAG_W = 20;

   typedef struct packed {
      logic attribute_table_index;
      logic page_cache_disable;
      logic page_write_through;
   } lptc_attr_t;

   typedef struct packed {
      logic [23:0] base;
      lptc_attr_t attr;
   } lptc_xlat_t;

   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_LOOK = 6'b000010,
      S_CHECK = 6'b000100,
      S_DIR = 6'b001000,
      S_TBL = 6'b010000,
      S_DONE = 6'b100000
   } lptc_state_t;
endpackage

// ### lptc_entries.sv
// One fully associative translation cache with round-robin refill.
// Assumes lookups, fills and invalidations all come from aclk logic.
module lptc_entries #(
   parameter int ENTRIES = 8,
   parameter int TAG_W = 20,
   parameter int DATA_W = 27
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [TAG_W-1:0] look_tag,
   output logic look_hit_q,
   output logic [DATA_W-1:0] look_data_q,
   input wire logic fill_en,
   input wire logic [TAG_W-1:0] fill_tag,
   input wire logic [DATA_W-1:0] fill_data,
   input wire logic fill_global,
   input wire logic inval_en,
   input wire logic [TAG_W-1:0] inval_tag,
   input wire logic flush_en,
   input wire logic flush_keep_global
);
   localparam int PTR_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
   logic [ENTRIES-1:0] valid_q;
   logic [ENTRIES-1:0] global_q;
   logic [TAG_W-1:0] tag_q [ENTRIES];
   logic [DATA_W-1:0] data_q [ENTRIES];
   logic [PTR_W-1:0] ptr_q;
   logic hit_d;
   logic [DATA_W-1:0] data_d;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         valid_q <= '0;
         global_q <= '0;
      end else begin
         for (int i = 0; i < ENTRIES; i++) begin
            if (flush_en && !(flush_keep_global && global_q[i])) begin
               valid_q[i] <= 1'b0;
            end else if (inval_en && tag_q[i] == inval_tag) begin
               valid_q[i] <= 1'b0;
            end
            if (fill_en && ptr_q == PTR_W'(i)) begin
               valid_q[i] <= 1'b1;
               global_q[i] <= fill_global;
            end
         end
      end
   end

   // Storage needs no reset; valid bits guard it
   always_ff @(posedge aclk) begin
      if (fill_en) begin
         tag_q[ptr_q] <= fill_tag;
         data_q[ptr_q] <= fill_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ptr_q <= '0;
      end else if (fill_en) begin
         ptr_q <= (ptr_q == PTR_W'(ENTRIES - 1)) ? '0 : ptr_q + 1'b1;
      end
   end

   always_comb begin
      hit_d = 1'b0;
      data_d = '0;
      for (int i = 0; i < ENTRIES; i++) begin
         if (valid_q[i] && tag_q[i] == look_tag) begin
            hit_d = 1'b1;
            data_d = data_q[i];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         look_hit_q <= 1'b0;
         look_data_q <= '0;
      end else begin
         look_hit_q <= hit_d;
         look_data_q <= data_d;
      end
   end
endmodule

// ### lptc_top.sv
// Translation cache top: register slave, lookup, walker, invalidation.
// Assumes one aclk; walker memory answers after it takes a request.
module lptc_top #(
   parameter int ENTRIES = lptc_pkg::TLB_ENTRIES_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic xlat_req_valid,
   output logic xlat_req_ready,
   input wire logic [31:0] xlat_req_linear,
   input wire logic xlat_req_fetch,
   output logic xlat_rsp_valid,
   output logic [35:0] xlat_rsp_phys,
   output lptc_pkg::lptc_attr_t xlat_rsp_attr,
   output logic xlat_rsp_fault,
   output logic xlat_rsp_hit,
   input wire logic task_switch_valid,
   input wire logic [31:0] task_switch_base,
   output logic walk_req_valid,
   input wire logic walk_req_ready,
   output logic [31:0] walk_req_addr,
   input wire logic walk_rsp_valid,
   input wire logic [31:0] walk_rsp_data
);
   import lptc_pkg::*;

   lptc_state_t state_q, state_d;
   logic [3:0] ctrl_q;
   logic [19:0] dirbase_q;
   logic [1:0] cpl_q;
   logic denied_q;
   logic [31:0] misses_q;
   logic aw_have_q, w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [31:0] lin_q;
   logic fetch_q;
   logic flush_q, keep_q, inval_q;
   logic [19:0] inval_tag_q;
   logic [TLB_COUNT-1:0] fill_q, fill_d;
   logic [19:0] fill_tag_q, fill_tag_d;
   lptc_xlat_t fill_data_q, fill_data_d;
   logic fill_glob_q, fill_glob_d;
   logic [TLB_COUNT-1:0] hit_v;
   lptc_xlat_t data_v [TLB_COUNT];
   logic wr_fire, wr_cmd, wr_priv_ok, large_hit, small_hit;
   logic done_set, done_fault, done_hit, walk_issue, large_map;
   logic [35:0] done_phys;
   lptc_attr_t done_attr;
   logic [31:0] walk_addr_d, rd_d;
   lptc_xlat_t lg, sm;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Register slave: address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         s_axi_awready <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         s_axi_awready <= 1'b0;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         s_axi_wready <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         s_axi_wready <= 1'b0;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_cmd = wr_fire && (awaddr_q == REG_INVPAGE || awaddr_q == REG_INVALL);
   assign wr_priv_ok = (cpl_q == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_q > REG_STATUS) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
         cpl_q <= PRIV_RESET;
      end else if (wr_fire && awaddr_q == REG_CTRL) begin
         ctrl_q <= 4'(merge({28'h0, ctrl_q}, wdata_q, wstrb_q));
      end else if (wr_fire && awaddr_q == REG_PRIV) begin
         cpl_q <= 2'(merge({30'h0, cpl_q}, wdata_q, wstrb_q));
      end
   end

   // Task switch takes priority over a software load in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dirbase_q <= DIRBASE_RESET;
      end else if (task_switch_valid) begin
         dirbase_q <= task_switch_base[31:12];
      end else if (wr_fire && awaddr_q == REG_DIRBASE) begin
         dirbase_q <= 20'(merge({dirbase_q, 12'h0}, wdata_q, wstrb_q) >> 12);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         denied_q <= 1'b0;
      end else if (wr_cmd && !wr_priv_ok) begin
         denied_q <= 1'b1;
      end else if (wr_fire && awaddr_q == REG_STATUS && wstrb_q[0] && wdata_q[ST_DENIED]) begin
         denied_q <= 1'b0;
      end
   end

   // Invalidation pulses; the global enable is sampled at flush time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flush_q <= 1'b0;
         keep_q <= 1'b0;
         inval_q <= 1'b0;
         inval_tag_q <= '0;
      end else begin
         flush_q <= task_switch_valid
            || (wr_fire && awaddr_q == REG_DIRBASE)
            || (wr_fire && awaddr_q == REG_INVALL && wr_priv_ok);
         keep_q <= ctrl_q[CTRL_GLOBAL_EN];
         inval_q <= wr_fire && awaddr_q == REG_INVPAGE && wr_priv_ok;
         if (wr_fire && awaddr_q == REG_INVPAGE) begin
            inval_tag_q <= wdata_q[31:12];
         end
      end
   end

   always_comb begin
      unique case (s_axi_araddr)
         REG_CTRL: rd_d = {28'h0, ctrl_q};
         REG_DIRBASE: rd_d = {dirbase_q, 12'h0};
         REG_PRIV: rd_d = {30'h0, cpl_q};
         REG_STATUS: rd_d = {30'h0, state_q != S_IDLE, denied_q};
         REG_MISSES: rd_d = misses_q;
         default: rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_d;
         s_axi_rresp <= (s_axi_araddr > REG_MISSES || s_axi_araddr[1:0] != 2'b00)
                        ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Four caches: index bit 1 is fetch, bit 0 is large
   for (genvar g = 0; g < TLB_COUNT; g++) begin : g_tlb
      logic [TAG_W-1:0] look_tag, inv_tag;
      logic [$bits(lptc_xlat_t)-1:0] dout;
      assign look_tag = (g % 2 == 1) ? {lin_q[31:22], 10'h000} : lin_q[31:12];
      assign inv_tag = (g % 2 == 1) ? {inval_tag_q[19:10], 10'h000} : inval_tag_q;
      assign data_v[g] = lptc_xlat_t'(dout);
      lptc_entries #(.ENTRIES(ENTRIES), .TAG_W(TAG_W), .DATA_W($bits(lptc_xlat_t))) u_ent (
         .aclk(aclk),
         .aresetn(aresetn),
         .look_tag(look_tag),
         .look_hit_q(hit_v[g]),
         .look_data_q(dout),
         .fill_en(fill_q[g]),
         .fill_tag(fill_tag_q),
         .fill_data(fill_data_q),
         .fill_global(fill_glob_q),
         .inval_en(inval_q),
         .inval_tag(inv_tag),
         .flush_en(flush_q),
         .flush_keep_global(keep_q)
      );
   end

   assign lg = data_v[{fetch_q, 1'b1}];
   assign sm = data_v[{fetch_q, 1'b0}];
   assign large_hit = hit_v[{fetch_q, 1'b1}] && ctrl_q[CTRL_SIZE_EXT];
   assign small_hit = hit_v[{fetch_q, 1'b0}];
   assign large_map = ctrl_q[CTRL_SIZE_EXT] && walk_rsp_data[ENT_PAGE_SIZE];

   always_comb begin
      state_d = state_q;
      done_set = 1'b0;
      done_phys = '0;
      done_attr = '0;
      done_fault = 1'b0;
      done_hit = 1'b0;
      walk_issue = 1'b0;
      walk_addr_d = '0;
      fill_d = '0;
      fill_tag_d = '0;
      fill_data_d = '0;
      fill_glob_d = 1'b0;
      unique case (state_q)
         S_IDLE: begin
            if (xlat_req_valid && xlat_req_ready) begin
               state_d = S_LOOK;
            end
         end
         S_LOOK: state_d = S_CHECK;
         S_CHECK: begin
            if (!ctrl_q[CTRL_PAGING_ON]) begin
               done_set = 1'b1;
               done_phys = {4'h0, lin_q};
            end else if (ctrl_q[CTRL_EXT_TABLE]) begin
               // Extended-table walks live elsewhere; report a fault
               done_set = 1'b1;
               done_fault = 1'b1;
            end else if (large_hit) begin
               done_set = 1'b1;
               done_hit = 1'b1;
               done_phys = {lg.base[23:10], lin_q[21:0]};
               done_attr = lg.attr;
            end else if (small_hit) begin
               done_set = 1'b1;
               done_hit = 1'b1;
               done_phys = {sm.base, lin_q[11:0]};
               done_attr = sm.attr;
            end else begin
               walk_issue = 1'b1;
               walk_addr_d = {dirbase_q, lin_q[31:22], 2'b00};
               state_d = S_DIR;
            end
         end
         S_DIR: begin
            if (walk_rsp_valid && !walk_req_valid) begin
               if (!walk_rsp_data[ENT_PRESENT]) begin
                  done_set = 1'b1;
                  done_fault = 1'b1;
               end else if (large_map) begin
                  done_set = 1'b1;
                  done_phys = {walk_rsp_data[16:13], walk_rsp_data[31:22],
                               lin_q[21:0]};
                  done_attr = '{walk_rsp_data[ENT_LARGE_ATTR],
                                walk_rsp_data[ENT_CACHE_DIS], walk_rsp_data[ENT_WRITE_THRU]};
                  fill_d[{fetch_q, 1'b1}] = 1'b1;
                  fill_tag_d = {lin_q[31:22], 10'h000};
                  fill_data_d = '{done_phys[35:12], done_attr};
                  fill_glob_d = walk_rsp_data[ENT_GLOBAL];
               end else begin
                  walk_issue = 1'b1;
                  walk_addr_d = {walk_rsp_data[31:12], lin_q[21:12], 2'b00};
                  state_d = S_TBL;
               end
            end
         end
         S_TBL: begin
            if (walk_rsp_valid && !walk_req_valid) begin
               done_set = 1'b1;
               if (!walk_rsp_data[ENT_PRESENT]) begin
                  done_fault = 1'b1;
               end else begin
                  done_phys = {4'h0, walk_rsp_data[31:12], lin_q[11:0]};
                  done_attr = '{walk_rsp_data[ENT_SMALL_ATTR],
                                walk_rsp_data[ENT_CACHE_DIS], walk_rsp_data[ENT_WRITE_THRU]};
                  fill_d[{fetch_q, 1'b0}] = 1'b1;
                  fill_tag_d = lin_q[31:12];
                  fill_data_d = '{done_phys[35:12], done_attr};
                  fill_glob_d = walk_rsp_data[ENT_GLOBAL];
               end
            end
         end
         S_DONE: state_d = S_IDLE;
      endcase
      if (done_set) begin
         state_d = S_DONE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= S_IDLE;
         xlat_req_ready <= 1'b0;
      end else begin
         state_q <= state_d;
         xlat_req_ready <= (state_d == S_IDLE);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lin_q <= '0;
         fetch_q <= 1'b0;
      end else if (state_q == S_IDLE && xlat_req_valid && xlat_req_ready) begin
         lin_q <= xlat_req_linear;
         fetch_q <= xlat_req_fetch;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xlat_rsp_valid <= 1'b0;
         xlat_rsp_phys <= '0;
         xlat_rsp_attr <= '0;
         xlat_rsp_fault <= 1'b0;
         xlat_rsp_hit <= 1'b0;
      end else begin
         xlat_rsp_valid <= done_set;
         if (done_set) begin
            xlat_rsp_phys <= done_phys;
            xlat_rsp_attr <= done_attr;
            xlat_rsp_fault <= done_fault;
            xlat_rsp_hit <= done_hit;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fill_q <= '0;
         fill_tag_q <= '0;
         fill_data_q <= '0;
         fill_glob_q <= 1'b0;
      end else begin
         fill_q <= fill_d;
         fill_tag_q <= fill_tag_d;
         fill_data_q <= fill_data_d;
         fill_glob_q <= fill_glob_d;
      end
   end

   // Walk request holds until taken; one outstanding read at most
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         walk_req_valid <= 1'b0;
         walk_req_addr <= '0;
      end else if (walk_issue) begin
         walk_req_valid <= 1'b1;
         walk_req_addr <= walk_addr_d;
      end else if (walk_req_ready) begin
         walk_req_valid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         misses_q <= '0;
      end else if (state_q == S_CHECK && walk_issue) begin
         misses_q <= misses_q + 32'h1;
      end
   end

   large_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_q == S_DIR && walk_rsp_valid && !walk_req_valid && walk_rsp_data[0] && large_map)
      |=> xlat_rsp_valid && xlat_rsp_phys == {$past(walk_rsp_data[16:13]),
          $past(walk_rsp_data[31:22]), lin_q[21:0]}) else $error("large page address wrong");
   attr_index_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_q == S_DIR && walk_rsp_valid && !walk_req_valid && walk_rsp_data[0] && large_map)
      |=> xlat_rsp_attr.attribute_table_index == $past(walk_rsp_data[12]))
      else $error("attribute index not from bit 12");
   miss_walk_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(walk_req_valid) |-> $past(state_q) == S_CHECK && !$past(large_hit)
      && !$past(small_hit) || $past(state_q) == S_DIR) else $error("walk without miss");
   hit_fast_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_q == S_CHECK && ctrl_q == 4'h1 && small_hit)
      |=> xlat_rsp_valid && xlat_rsp_hit && !walk_req_valid) else $error("hit not used");
   priv_deny_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_cmd && cpl_q != 2'h0) |=> denied_q && !flush_q && !inval_q)
      else $error("unprivileged invalidate not denied");
   base_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && awaddr_q == REG_DIRBASE) |=> flush_q && keep_q == $past(ctrl_q[3]))
      else $error("base load did not flush");
   task_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
      task_switch_valid |=> flush_q ##0 dirbase_q == $past(task_switch_base[31:12]))
      else $error("task switch did not flush");
   page_inval_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && awaddr_q == REG_INVPAGE && cpl_q == 2'h0)
      |=> inval_q && inval_tag_q == $past(wdata_q[31:12])) else $error("page invalidate lost");
   fill_sep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $onehot0(fill_q) && (!(fill_q[3] || fill_q[1]) || fill_tag_q[9:0] == 10'h000))
      else $error("fill went to wrong cache");
   no_large_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_q == S_DIR && walk_rsp_valid && !walk_req_valid && walk_rsp_data[0]
       && !ctrl_q[CTRL_SIZE_EXT]) |=> state_q == S_TBL) else $error("large without extension");
endmodule

// ### lptc_mem_model.sv
// Table memory model answering the walker's reads.
// Assumes one aclk; entry contents are made up from the read address.
module lptc_mem_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic glob,
   input wire logic walk_req_valid,
   output logic walk_req_ready,
   input wire logic [31:0] walk_req_addr,
   output logic walk_rsp_valid,
   output logic [31:0] walk_rsp_data,
   output logic [7:0] walks
);
   logic pend_q;
   logic [31:0] addr_q;
   assign walk_req_ready = !pend_q;
   always_ff @(posedge aclk) begin
      walk_rsp_valid <= 1'b0;
      // Data toggles when idle, so stale values never look valid
      walk_rsp_data <= ~walk_rsp_data;
      if (!aresetn) begin
         pend_q <= 1'b0;
         walks <= 8'h00;
         walk_rsp_data <= 32'h0;
      end else if (pend_q) begin
         pend_q <= 1'b0;
         walk_rsp_valid <= 1'b1;
         // Large entry with page size bit set
         walk_rsp_data <= {addr_q[11:2] ^ 10'h155, 5'h00, 4'h9, 1'b1, 3'h0, glob, 1'b1, 7'h11};
      end else if (walk_req_valid) begin
         pend_q <= 1'b1;
         addr_q <= walk_req_addr;
         walks <= walks + 8'h01;
      end
   end
endmodule

// ### testbench.sv
// Self-checking bench for the translation cache top.
// Assumes the table memory model on the walker port.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import lptc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, glob = 1'b0, xlat_req_fetch = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic xlat_req_valid = 1'b0, task_switch_valid = 1'b0, small_mode = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, xlat_req_linear = 32'h0, task_switch_base = 32'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic xlat_req_ready, xlat_rsp_valid, xlat_rsp_fault, xlat_rsp_hit;
   logic walk_req_valid, walk_req_ready, walk_rsp_valid;
   logic [7:0] walks;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, walk_req_addr, walk_rsp_data;
   logic [35:0] xlat_rsp_phys;
   lptc_attr_t xlat_rsp_attr;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   localparam logic [31:0] A = 32'h12345678, B = 32'h0abcd123;
   lptc_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
      .s_axi_bready(1'b1), .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready(1'b1), .s_axi_rdata, .s_axi_rresp, .xlat_req_valid,
      .xlat_req_ready, .xlat_req_linear, .xlat_req_fetch, .xlat_rsp_valid, .xlat_rsp_phys,
      .xlat_rsp_attr, .xlat_rsp_fault, .xlat_rsp_hit, .task_switch_valid, .task_switch_base,
      .walk_req_valid, .walk_req_ready, .walk_req_addr, .walk_rsp_valid, .walk_rsp_data);
   lptc_mem_model mem (.aclk, .aresetn, .glob, .walk_req_valid, .walk_req_ready,
      .walk_req_addr, .walk_rsp_valid, .walk_rsp_data, .walks);
   task wrap_up;
      if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task cmp(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Response ready stays high, so only valids are released
   task wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      cmp(36'(s_axi_bresp), 36'(RESP_OKAY));
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task xl(input logic [31:0] lin, input logic f, input logic h, input logic flt);
      xlat_req_linear <= lin;
      xlat_req_fetch <= f;
      xlat_req_valid <= 1'b1;
      do @(posedge aclk); while (xlat_req_ready !== 1'b1);
      xlat_req_valid <= 1'b0;
      do @(posedge aclk); while (xlat_rsp_valid !== 1'b1);
      cmp(36'(xlat_rsp_fault), 36'(flt));
      if (!flt) begin
         cmp(36'(xlat_rsp_hit), 36'(h));
         cmp(xlat_rsp_phys, small_mode ? {4'h0, lin[21:12] ^ 10'h155, 9'h009, 1'b1, lin[11:0]}
                                       : {4'h9, lin[31:22] ^ 10'h155, lin[21:0]});
         cmp(36'(xlat_rsp_attr), 36'h6);
      end
   endtask
   task t_large;
      wr(REG_CTRL, 32'h5);
      wr(REG_DIRBASE, 32'h1000);
      xl(A, 1'b0, 1'b0, 1'b0);
      cmp(36'(walks), 36'h1);
      xl(A, 1'b0, 1'b1, 1'b0);
      cmp(36'(walks), 36'h1);
      xl(A, 1'b1, 1'b0, 1'b0);
   endtask
   task t_global;
      glob <= 1'b1;
      wr(REG_CTRL, 32'hd);
      xl(B, 1'b0, 1'b0, 1'b0);
      glob <= 1'b0;
      wr(REG_DIRBASE, 32'h3000);
      xl(B, 1'b0, 1'b1, 1'b0);
      xl(A, 1'b0, 1'b0, 1'b0);
      task_switch_base <= 32'h5000;
      task_switch_valid <= 1'b1;
      @(posedge aclk);
      task_switch_valid <= 1'b0;
      @(posedge aclk);
      xl(B, 1'b0, 1'b1, 1'b0);
      xl(A, 1'b0, 1'b0, 1'b0);
   endtask
   task t_inval;
      logic [31:0] d;
      logic [1:0] r;
      wr(REG_PRIV, 32'h3);
      wr(REG_INVPAGE, A);
      xl(A, 1'b0, 1'b1, 1'b0);
      rd(REG_STATUS, d, r);
      cmp(36'(d[ST_DENIED]), 36'h1);
      wr(REG_PRIV, 32'h0);
      wr(REG_INVPAGE, B);
      glob <= 1'b1;
      xl(B, 1'b0, 1'b0, 1'b0);
      glob <= 1'b0;
      wr(REG_CTRL, 32'h5);
      wr(REG_INVALL, 32'h0);
      xl(B, 1'b0, 1'b0, 1'b0);
      wr(REG_CTRL, 32'h7);
      xl(A, 1'b0, 1'b0, 1'b1);
      rd(8'h1c, d, r);
      cmp(36'(r), 36'(RESP_SLVERR));
   endtask
   // Size extension off: directory entry points to a table
   task t_small;
      logic [31:0] d;
      logic [1:0] r;
      small_mode = 1'b1;
      wr(REG_CTRL, 32'h1);
      xl(B, 1'b0, 1'b0, 1'b0);
      xl(B, 1'b0, 1'b1, 1'b0);
      cmp(36'(walks), 36'h9);
      rd(REG_MISSES, d, r);
      cmp(36'(d), 36'h8);
   endtask
   // Hang guard, far above the few hundred cycles needed
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         wrap_up;
      end
   end
   initial begin
      forever #5 aclk = ~aclk;
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_large;
      t_global;
      t_inval;
      t_small;
      wrap_up;
   end
endmodule
